/* File: pdm_pkg.sv */
// Shared constants and types of the pulse width / duty cycle setup block
package pdm_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CMD        = 8'h00;
    localparam logic [7:0] ADDR_CONFIG     = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_OUTBUF     = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18;

    // Command codes written to the command register
    localparam logic [3:0] CMD_PW_SETUP  = 4'h1;
    localparam logic [3:0] CMD_DC_SETUP  = 4'h2;
    localparam logic [3:0] CMD_ACV_SETUP = 4'h3;
    localparam logic [3:0] CMD_ACI_SETUP = 4'h4;
    localparam logic [3:0] CMD_INIT      = 4'h5;
    localparam logic [3:0] CMD_READ      = 4'h6;
    localparam logic [3:0] CMD_FETCH     = 4'h7;
    localparam logic [3:0] CMD_BUS_TRIG  = 4'h8;
    localparam logic [3:0] CMD_ABORT     = 4'h9;

    // Interrupt event bit positions
    localparam int EV_DONE  = 0;
    localparam int EV_RANGE = 1;
    localparam int EV_OVL   = 2;
    localparam int EV_ERR   = 3;
    localparam int EV_W     = 4;

    // Reading codes
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
    localparam logic [31:0] RD_POS_OVL   = 32'h4000_0000;
    localparam logic [31:0] RD_NEG_OVL   = 32'h8000_0000;
    localparam logic [31:0] RD_RANGE_CHG = 32'hC000_0000;

    // Range scaling of front end counts
    localparam logic [15:0] FS_COUNTS  = 16'h2710;
    localparam int          DOWN_PCT   = 10;
    localparam int          UP_PCT     = 120;
    localparam logic [15:0] DOWN_LIMIT = 16'(int'(FS_COUNTS) * DOWN_PCT / 100);
    localparam logic [15:0] UP_LIMIT   = 16'(int'(FS_COUNTS) * UP_PCT / 100);
    localparam logic [2:0]  RANGE_MAX  = 3'h4;
    localparam logic [2:0]  RANGE_RST  = 3'h0;

    // Range relay settling
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          RANGE_SETTLE_NS = 1000;
    localparam logic [7:0]  RANGE_SETTLE_CYC =
        8'((RANGE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Reading memory
    localparam int MEM_DEPTH = 8;
    localparam int MEM_AW    = 3;

    typedef enum logic [1:0] {TRIG_SRC_IMM, TRIG_SRC_BUS, TRIG_SRC_EXT} trig_src_t;
    typedef enum logic [1:0] {FUNC_ACV, FUNC_ACI, FUNC_PWIDTH, FUNC_DCYCLE} meas_func_t;
    typedef enum logic [1:0] {TRIG_IDLE, TRIG_WAIT, TRIG_MEAS} trig_state_t;

    typedef struct packed {
        logic      dc_polarity;
        logic      pw_polarity;
        logic      calc_en;
        trig_src_t trig_src;
        logic      auto_range;
        logic [2:0] range;
    } cfg_t;

    localparam logic PW_POL_RST = 1'b0;
    localparam logic DC_POL_RST = 1'b0;
    localparam cfg_t CFG_RST = '{dc_polarity: DC_POL_RST, pw_polarity: PW_POL_RST,
                                 calc_en: 1'b0, trig_src: TRIG_SRC_IMM,
                                 auto_range: 1'b1, range: RANGE_RST};

    typedef struct packed {
        logic        present;
        logic [15:0] value;
    } meas_sample_t;

endpackage

/* File: reading_store.sv */
// Reading memory with registered read of the latest entry
`timescale 1ns/1ps
module reading_store
    import pdm_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Write and clear
    input  wire logic             wr_en,
    input  wire logic [31:0]      wr_data,
    input  wire logic             clear,
    // Read of newest reading
    input  wire logic             rd_en,
    output logic      [31:0]      rd_data,
    output logic      [MEM_AW:0]  count
);
    logic [31:0]       store [MEM_DEPTH];
    logic [MEM_AW-1:0] wptr;

    always_ff @(posedge mclk)
    begin
        if (wr_en)
        begin
            store[wptr] <= wr_data;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wptr  <= '0;
            count <= '0;
        end
        else if (clear)
        begin
            wptr  <= '0;
            count <= '0;
        end
        else if (wr_en)
        begin
            wptr <= wptr + 1'b1;
            if (count != (MEM_AW+1)'(MEM_DEPTH))
            begin
                count <= count + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data <= '0;
        end
        else if (rd_en)
        begin
            rd_data <= store[wptr - 1'b1];
        end
    end
endmodule

/* File: pulse_duty_measure_config.sv */
// Command, trigger and ranging logic for pulse width and duty cycle setup
`timescale 1ns/1ps
module pulse_duty_measure_config
    import pdm_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // Front end
    input  wire logic         fe_valid,
    input  wire meas_sample_t fe_sample,
    input  wire logic         ext_trig,
    output logic              meas_start,
    output logic      [2:0]   meas_range,
    output meas_func_t        meas_func,
    // Interrupt
    output logic              irq
);
    cfg_t            cfg;
    meas_func_t      func;
    logic            path_current;
    logic            path_ok;
    trig_state_t     trig_state;
    logic            read_pend;
    logic            fetch_pend;
    logic [31:0]     outbuf;
    logic            out_full;
    logic [7:0]      settle_cnt;
    logic            range_busy;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic            ext_meta;
    logic            ext_sync;
    logic            ext_prev;
    logic [31:0]     mem_rdata;
    logic [MEM_AW:0] mem_count;

    // Bus decode
    logic        apb_access;
    logic        apb_done;
    logic        wr_done;
    logic        rd_done;
    logic        addr_ok;
    logic [31:0] rd_mux;
    logic        cmd_wr;
    logic [3:0]  cmd;

    assign apb_access = psel && penable;
    assign apb_done   = apb_access && pready;
    assign wr_done    = apb_done && pwrite && !pslverr;
    assign rd_done    = apb_done && !pwrite && !pslverr;
    assign cmd_wr     = wr_done && (paddr == ADDR_CMD);
    assign cmd        = pwdata[3:0];

    // Command qualification
    logic is_setup;
    logic pd_ok;
    logic arm_ok;
    logic do_init;
    logic do_read;
    logic read_busy;
    logic do_fetch;
    logic cmd_err;
    logic fire;
    logic done;

    assign pd_ok     = cmd_wr && (cmd == CMD_PW_SETUP || cmd == CMD_DC_SETUP) && path_ok;
    assign is_setup  = pd_ok || (cmd_wr && (cmd == CMD_ACV_SETUP || cmd == CMD_ACI_SETUP));
    assign arm_ok    = (trig_state == TRIG_IDLE) && !range_busy;
    assign do_init   = cmd_wr && cmd == CMD_INIT && arm_ok;
    assign do_read   = cmd_wr && cmd == CMD_READ && arm_ok;
    assign read_busy = cmd_wr && (cmd == CMD_READ || cmd == CMD_FETCH) && range_busy;
    assign do_fetch  = cmd_wr && cmd == CMD_FETCH && !range_busy && mem_count != '0;
    // Setup without a configured AC path, or arm while not idle, is refused
    assign cmd_err   = cmd_wr && (((cmd == CMD_PW_SETUP || cmd == CMD_DC_SETUP) && !path_ok)
                       || ((cmd == CMD_INIT || cmd == CMD_READ) && trig_state != TRIG_IDLE)
                       || (cmd == CMD_FETCH && !range_busy && mem_count == '0));
    assign done      = (trig_state == TRIG_MEAS) && fe_valid;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        if (paddr == ADDR_CMD)
        begin
            rd_mux = 32'h0000_0000;
        end
        else if (paddr == ADDR_CONFIG)
        begin
            rd_mux = {19'h0, path_current, 1'b0, func, cfg};
        end
        else if (paddr == ADDR_STATUS)
        begin
            rd_mux = {24'h0, range_busy, out_full, mem_count, trig_state};
        end
        else if (paddr == ADDR_OUTBUF)
        begin
            rd_mux = outbuf;
        end
        else if (paddr == ADDR_IRQ_STATUS)
        begin
            rd_mux = {28'h0, irq_status};
        end
        else if (paddr == ADDR_IRQ_ENABLE)
        begin
            rd_mux = {28'h0, irq_enable};
        end
        else if (paddr == ADDR_IRQ_CLEAR)
        begin
            rd_mux = 32'h0000_0000;
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // One wait state, registered answer
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_access && !pready;
            pslverr <= apb_access && !pready && !addr_ok;
            if (apb_access && !pready && !pwrite)
            begin
                prdata <= rd_mux;
            end
        end
    end

    // External trigger synchroniser
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= ext_trig;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_comb
    begin
        case (cfg.trig_src)
            TRIG_SRC_IMM: fire = 1'b1;
            TRIG_SRC_BUS: fire = cmd_wr && cmd == CMD_BUS_TRIG;
            TRIG_SRC_EXT: fire = ext_sync && !ext_prev;
            default:      fire = 1'b0;
        endcase
    end

    // Reading evaluation and autoranging
    logic [15:0] mag;
    logic        step_up;
    logic        step_down;
    logic        ovl;
    logic [31:0] next_reading;

    assign mag = fe_sample.value[15] ? (~fe_sample.value + 16'h0001) : fe_sample.value;

    always_comb
    begin
        step_up      = 1'b0;
        step_down    = 1'b0;
        ovl          = 1'b0;
        next_reading = {2'h0, 11'h000, cfg.range, fe_sample.value};
        if (!fe_sample.present)
        begin
            next_reading = RD_ZERO;
        end
        else if (range_busy)
        begin
            next_reading = RD_RANGE_CHG;
        end
        else if (cfg.auto_range && mag > UP_LIMIT && cfg.range != RANGE_MAX)
        begin
            step_up      = 1'b1;
            next_reading = RD_RANGE_CHG;
        end
        else if (cfg.auto_range && mag < DOWN_LIMIT && cfg.range != 3'h0)
        begin
            step_down    = 1'b1;
            next_reading = RD_RANGE_CHG;
        end
        else if (mag > FS_COUNTS)
        begin
            ovl          = 1'b1;
            next_reading = fe_sample.value[15] ? RD_NEG_OVL : RD_POS_OVL;
        end
    end

    // Configuration, function and AC path
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg          <= CFG_RST;
            func         <= FUNC_ACV;
            path_current <= 1'b0;
            path_ok      <= 1'b0;
        end
        else if (cmd_wr && (cmd == CMD_ACV_SETUP || cmd == CMD_ACI_SETUP))
        begin
            cfg          <= CFG_RST;
            func         <= (cmd == CMD_ACV_SETUP) ? FUNC_ACV : FUNC_ACI;
            path_current <= (cmd == CMD_ACI_SETUP);
            path_ok      <= 1'b1;
        end
        else if (pd_ok)
        begin
            // Range and autorange kept from the current configuration
            cfg.trig_src <= TRIG_SRC_IMM;
            cfg.calc_en  <= 1'b0;
            if (cmd == CMD_PW_SETUP)
            begin
                cfg.pw_polarity <= PW_POL_RST;
                func            <= FUNC_PWIDTH;
            end
            else
            begin
                cfg.dc_polarity <= DC_POL_RST;
                func            <= FUNC_DCYCLE;
            end
        end
        else if (wr_done && paddr == ADDR_CONFIG)
        begin
            cfg <= cfg_t'(pwdata[8:0]);
        end
        else if (done && step_up)
        begin
            cfg.range <= cfg.range + 3'h1;
        end
        else if (done && step_down)
        begin
            cfg.range <= cfg.range - 3'h1;
        end
    end

    // Range settling window
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            settle_cnt <= 8'h00;
            range_busy <= 1'b0;
        end
        else if (done && (step_up || step_down))
        begin
            settle_cnt <= RANGE_SETTLE_CYC;
            range_busy <= 1'b1;
        end
        else if (settle_cnt > 8'h01)
        begin
            settle_cnt <= settle_cnt - 8'h01;
        end
        else
        begin
            settle_cnt <= 8'h00;
            range_busy <= 1'b0;
        end
    end

    // Trigger state machine
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trig_state <= TRIG_IDLE;
            meas_start <= 1'b0;
            read_pend  <= 1'b0;
        end
        else
        begin
            meas_start <= 1'b0;
            if (is_setup || (cmd_wr && cmd == CMD_ABORT))
            begin
                trig_state <= TRIG_IDLE;
                read_pend  <= 1'b0;
            end
            else
            begin
                case (trig_state)
                    TRIG_IDLE:
                    begin
                        if (do_init || do_read)
                        begin
                            trig_state <= TRIG_WAIT;
                            read_pend  <= do_read;
                        end
                    end
                    TRIG_WAIT:
                    begin
                        if (fire)
                        begin
                            trig_state <= TRIG_MEAS;
                            meas_start <= 1'b1;
                        end
                    end
                    TRIG_MEAS:
                    begin
                        if (fe_valid)
                        begin
                            trig_state <= TRIG_IDLE;
                            read_pend  <= 1'b0;
                        end
                    end
                    default: trig_state <= TRIG_IDLE;
                endcase
            end
        end
    end

    reading_store u_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .wr_en   (done),
        .wr_data (next_reading),
        .clear   (do_init || do_read),
        .rd_en   (do_fetch),
        .rd_data (mem_rdata),
        .count   (mem_count)
    );

    // Output buffer; a bus read of it empties it, a new load wins
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outbuf     <= 32'h0000_0000;
            out_full   <= 1'b0;
            fetch_pend <= 1'b0;
        end
        else
        begin
            fetch_pend <= do_fetch;
            if (done && read_pend)
            begin
                outbuf   <= next_reading;
                out_full <= 1'b1;
            end
            else if (read_busy)
            begin
                outbuf   <= RD_RANGE_CHG;
                out_full <= 1'b1;
            end
            else if (fetch_pend)
            begin
                outbuf   <= mem_rdata;
                out_full <= 1'b1;
            end
            else if (rd_done && paddr == ADDR_OUTBUF)
            begin
                out_full <= 1'b0;
            end
        end
    end

    // Interrupts, set wins over clear
    logic [EV_W-1:0] events;

    always_comb
    begin
        events           = '0;
        events[EV_DONE]  = done;
        events[EV_RANGE] = done && (step_up || step_down);
        events[EV_OVL]   = done && ovl;
        events[EV_ERR]   = cmd_err;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_status <= '0;
            irq_enable <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            if (wr_done && paddr == ADDR_IRQ_CLEAR)
            begin
                irq_status <= (irq_status & ~pwdata[EV_W-1:0]) | events;
            end
            else
            begin
                irq_status <= irq_status | events;
            end
            if (wr_done && paddr == ADDR_IRQ_ENABLE)
            begin
                irq_enable <= pwdata[EV_W-1:0];
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    assign meas_range = cfg.range;
    assign meas_func  = func;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_pw_setup;
        pd_ok && cmd == CMD_PW_SETUP;
    endsequence

    sequence s_dc_setup;
        pd_ok && cmd == CMD_DC_SETUP;
    endsequence

    sequence s_read_done;
        done && read_pend && !is_setup;
    endsequence

    AST_SETUP_NOT_WAIT: assert property (is_setup |=> trig_state == TRIG_IDLE && !meas_start)
        else $error("setup left trigger armed");
    AST_PW_SETUP: assert property (s_pw_setup |=> func == FUNC_PWIDTH && cfg.pw_polarity == PW_POL_RST
                                   && cfg.range == $past(cfg.range))
        else $error("pulse width setup wrong");
    AST_DC_SETUP: assert property (s_dc_setup |=> func == FUNC_DCYCLE && cfg.dc_polarity == DC_POL_RST)
        else $error("duty cycle setup wrong");
    AST_SETUP_TRIG_SRC: assert property (pd_ok |=> cfg.trig_src == TRIG_SRC_IMM && !cfg.calc_en)
        else $error("setup kept trigger source or calc");
    AST_NO_SIGNAL_ZERO: assert property (done && !fe_sample.present |-> next_reading == RD_ZERO)
        else $error("absent signal not zero");
    AST_RANGE_DOWN: assert property (done && !is_setup && !(wr_done && paddr == ADDR_CONFIG) && cfg.auto_range
                                     && fe_sample.present && !range_busy && mag < DOWN_LIMIT && cfg.range != 3'h0
                                     |=> cfg.range == $past(cfg.range) - 3'h1 && range_busy)
        else $error("no down range");
    AST_RANGE_UP: assert property (done && !is_setup && !(wr_done && paddr == ADDR_CONFIG) && cfg.auto_range
                                   && fe_sample.present && !range_busy && mag > UP_LIMIT && cfg.range != RANGE_MAX
                                   |=> cfg.range == $past(cfg.range) + 3'h1 && range_busy)
        else $error("no up range");
    AST_MANUAL_OVL: assert property (done && !cfg.auto_range && fe_sample.present && !range_busy
                                     && mag > FS_COUNTS
                                     |-> next_reading == (fe_sample.value[15] ? RD_NEG_OVL : RD_POS_OVL))
        else $error("overload code wrong");
    AST_BUSY_QUERY: assert property (read_busy && !(done && read_pend) |=> outbuf == RD_RANGE_CHG && out_full)
        else $error("range change sentinel missing");
    AST_READ_OUT: assert property (s_read_done |=> outbuf == $past(next_reading) && out_full
                                   && trig_state == TRIG_IDLE)
        else $error("read result not in output buffer");
    AST_INIT_WAIT: assert property (do_init && !is_setup |=> trig_state == TRIG_WAIT && mem_count == '0)
        else $error("initiate did not arm");
    AST_WAIT_HOLDS: assert property (trig_state == TRIG_WAIT && !fire && !is_setup && !(cmd_wr && cmd == CMD_ABORT)
                                     |=> trig_state == TRIG_WAIT && !meas_start)
        else $error("measured without trigger");
    AST_FETCH_COPY: assert property (do_fetch && !read_busy && !(done && read_pend)
                                     ##1 !(done && read_pend) && !read_busy |=> out_full && outbuf == mem_rdata)
        else $error("fetch did not copy");
    AST_DONE_IDLE: assert property (done && !is_setup |=> trig_state == TRIG_IDLE ##1 trig_state != TRIG_MEAS)
        else $error("trigger not idle after reading");
endmodule

/* File: fe_model.sv */
// Front end model answering each measurement start with one sample
`timescale 1ns/1ps
module fe_model
    import pdm_pkg::*;
(
    // Clock and start
    input  wire logic         mclk,
    input  wire logic         meas_start,
    // Sample to deliver
    input  wire meas_sample_t smp,
    output logic              fe_valid,
    output meas_sample_t      fe_sample
);
    logic [1:0] dly = 2'h0;
    initial fe_valid = 1'b0;
    initial fe_sample = '0;
    always @(posedge mclk)
    begin
        dly <= {dly[0], meas_start};
        fe_valid <= dly[1];
        // Garbage outside the valid cycle
        fe_sample <= dly[1] ? smp : ~smp;
    end
endmodule

/* File: tb_pulse_duty_measure_config.sv */
// Self-checking bench of the pulse width / duty cycle setup block
`timescale 1ns/1ps
module tb_pulse_duty_measure_config;
    import pdm_pkg::*;
    typedef struct packed {logic [8:0] cfg; meas_sample_t s; logic [31:0] rd; logic [2:0] rg;} row_t;
    logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_trig = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, fe_valid, meas_start, irq;
    logic [2:0] meas_range;
    meas_func_t meas_func;
    meas_sample_t fe_sample, smp = '0;
    int miscompares = 0, n_compared = 0, ns = 0, n0;
    row_t rows [7] = '{'{9'h008, {1'b1, 16'h1388}, 32'h0000_1388, 3'h0},
        '{9'h008, {1'b0, 16'h1388}, RD_ZERO, 3'h0}, '{9'h008, {1'b1, 16'h3000}, RD_RANGE_CHG, 3'h1},
        '{9'h009, {1'b1, 16'h0100}, RD_RANGE_CHG, 3'h0}, '{9'h000, {1'b1, 16'h2800}, RD_POS_OVL, 3'h0},
        '{9'h000, {1'b1, 16'hD800}, RD_NEG_OVL, 3'h0}, '{9'h002, {1'b1, 16'h0064}, 32'h0002_0064, 3'h2}};
    pulse_duty_measure_config i_dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fe_valid, .fe_sample, .ext_trig, .meas_start, .meas_range, .meas_func, .irq);
    fe_model i_fe (.mclk, .meas_start, .smp, .fe_valid, .fe_sample);
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (meas_start === 1'b1) ns <= ns + 1;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic idle_wait;
        repeat (20)
        begin
            bus(1'b0, ADDR_STATUS, 32'h0);
            if (q[1:0] === 2'h0) break;
        end
        chk("idle", 32'h0, q[1:0]);
    endtask
    task automatic final_report;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        chk("func", FUNC_ACV, meas_func);
        bus(1'b0, 8'h1C, 32'h0);
        chk("pslverr", 32'h1, err);
        bus(1'b1, ADDR_CMD, CMD_PW_SETUP);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk("irq_status", 32'h8, q);
        bus(1'b1, ADDR_IRQ_CLEAR, 32'hF);
        bus(1'b1, ADDR_CMD, CMD_ACV_SETUP);
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        foreach (rows[i])
        begin
            smp <= rows[i].s;
            bus(1'b1, ADDR_CONFIG, rows[i].cfg);
            bus(1'b1, ADDR_CMD, CMD_READ);
            idle_wait();
            bus(1'b0, ADDR_OUTBUF, 32'h0);
            chk("outbuf", rows[i].rd, q);
            chk("range", rows[i].rg, meas_range);
            repeat (60) @(posedge mclk);
        end
        chk("irq", 32'h1, irq);
        smp <= '{1'b1, 16'h3000};
        bus(1'b1, ADDR_CONFIG, 32'h8);
        bus(1'b1, ADDR_CMD, CMD_READ);
        idle_wait();
        bus(1'b0, ADDR_OUTBUF, 32'h0);
        smp <= '{1'b1, 16'h1388};
        bus(1'b1, ADDR_CMD, CMD_READ);
        idle_wait();
        chk("busy_full", 32'h1, q[6]);
        chk("busy_flag", 32'h1, q[7]);
        bus(1'b0, ADDR_OUTBUF, 32'h0);
        chk("busy_read", RD_RANGE_CHG, q);
        chk("busy_range", 32'h1, meas_range);
        repeat (60) @(posedge mclk);
        bus(1'b1, ADDR_IRQ_CLEAR, 32'hF);
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        chk("irq_clr", 32'h0, irq);
        bus(1'b1, ADDR_CONFIG, 32'h1DA);
        bus(1'b1, ADDR_CMD, CMD_PW_SETUP);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk("pw_cfg", 32'h50A, q);
        chk("pw_func", FUNC_PWIDTH, meas_func);
        bus(1'b1, ADDR_CONFIG, 32'h1DA);
        bus(1'b1, ADDR_CMD, CMD_DC_SETUP);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk("dc_cfg", 32'h68A, q);
        bus(1'b1, ADDR_CONFIG, 32'h10);
        n0 = ns;
        bus(1'b1, ADDR_CMD, CMD_INIT);
        repeat (10) @(posedge mclk);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("wait_state", 32'h1, q[1:0]);
        chk("no_start", n0, ns);
        bus(1'b1, ADDR_CMD, CMD_PW_SETUP);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("setup_idle", 32'h0, q[1:0]);
        smp <= '{1'b1, 16'h0064};
        bus(1'b1, ADDR_CONFIG, 32'h12);
        bus(1'b1, ADDR_CMD, CMD_INIT);
        bus(1'b1, ADDR_CMD, CMD_BUS_TRIG);
        idle_wait();
        chk("status", 32'h4, q);
        chk("masked_irq", 32'h0, irq);
        bus(1'b1, ADDR_CMD, CMD_FETCH);
        repeat (3) @(posedge mclk);
        bus(1'b0, ADDR_OUTBUF, 32'h0);
        chk("fetch", 32'h0002_0064, q);
        chk("starts", n0 + 1, ns);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk("done_bit", 32'h1, q);
        bus(1'b1, ADDR_CMD, CMD_ACI_SETUP);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk("aci_cfg", 32'h1208, q);
        bus(1'b1, ADDR_CONFIG, 32'h22);
        bus(1'b1, ADDR_CMD, CMD_INIT);
        ext_trig <= 1'b1;
        idle_wait();
        chk("ext_starts", n0 + 2, ns);
        ext_trig <= 1'b0;
        bus(1'b1, ADDR_CMD, CMD_INIT);
        bus(1'b1, ADDR_CMD, CMD_ABORT);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("abort_idle", 32'h0, q[1:0]);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk("rst_cfg", 32'h8, q);
        chk("rst_func", FUNC_ACV, meas_func);
        final_report();
    end
endmodule
